/* rtl/swrc_top.sv */
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// Notes on behaviour
// - Reset during light sleep leaves it and restarts through the reset vector.
// - After any reset release the CPU stays stopped while option byte is referenced.
// - Light sleep: unmasked request resumes or vectors per interrupt enable; masked stays.
// - Deep sleep entered on stop; a pending unmasked timer, detector or external request releases it at once.
// - Immediate deep-sleep release still waits about 34 us, plus crystal settle.
// - Deep sleep stops system oscillator, CPU, sixteen-bit timer, peripheral-clocked timer.
// - Deep sleep holds port latches; power-on-clear, detector, external interrupts stay alive.
// - Low-speed clocked eight-bit timer counts while its oscillator runs; system-clocked watchdog stops.
// - Low-speed watchdog runs in standby unless its oscillator is stoppable and stopped.
// - Deep sleep wakes on timer, detector or external request, then resumes or vectors.
// - Leaving deep sleep keeps operation stopped 17 to 67 us, typically 34.
// - Reset in deep sleep acts at once; oscillator stabilization follows its release.
// - Reset comes from pin, watchdog overflow, power-on-clear or low-voltage detector.
// - All reset sources act alike; execution starts at the vector in 0000H.
// - During reset and stabilization pins float; reset indicator output drives low.
// - Low pin holds reset; high releases after option reference and crystal settle.
// - Watchdog reset releases by itself, then the same release sequence follows.
// - Power-on-clear and detector resets release once supply rises above level.
// - While reset is active both oscillators are stopped.
// - Pin used as port still resets if low between power-on-clear and option reference.
// - Deep-sleep settle wait applies with crystal only, 2^10 to 2^17 clocks.
// - Reset flags read zero after pin or power-on-clear reset; reading clears them.
module swrc_top #(
  parameter int OB_REF_CYC = swrc_pkg::OB_REF_US * swrc_pkg::CLK_MHZ,
  parameter int SETTLE_CYC2 = 1 << swrc_pkg::SETTLE_EXP2,
  parameter int SETTLE_CYC3 = 1 << swrc_pkg::SETTLE_EXP3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic reset_pin_is_port,
  output logic reset_pin_input_port,
  input wire logic poc_low,
  input wire logic lvi_low,
  input wire logic wdt_overflow,
  input wire logic osc_is_crystal,
  input wire logic [1:0] ob_settle_sel,
  input wire logic lsosc_stoppable,
  input wire logic lsosc_stop_req,
  input wire logic h1_on_lsosc,
  input wire logic wdt_on_lsosc,
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire swrc_pkg::swrc_wake_t int_req_flag,
  input wire swrc_pkg::swrc_wake_t interrupt_mask_flag,
  input wire logic global_interrupt_enable,
  output logic cpu_clk_en,
  output logic cpu_resume_next,
  output logic cpu_vector_int,
  output logic cpu_reset_start,
  output logic [15:0] reset_vector_addr,
  output logic sys_osc_en,
  output logic lsosc_en,
  output logic timer16_en,
  output logic timer8_en,
  output logic wdt_en,
  output logic port_latch_hold,
  output logic detectors_alive,
  output logic pins_hiz,
  output logic reset_indicator_port_output,
  output logic reset_indicator_port_output_oe
);
  localparam int CW = swrc_pkg::CNT_W;
  localparam logic [CW-1:0] LD_OBREF = CW'(OB_REF_CYC - 1);
  localparam logic [CW-1:0] LD_WAIT = CW'(swrc_pkg::STOP_WAIT_CYC - 1);
  localparam logic [CW-1:0] LD_S0 = CW'((1 << swrc_pkg::SETTLE_EXP0) - 1);
  localparam logic [CW-1:0] LD_S1 = CW'((1 << swrc_pkg::SETTLE_EXP1) - 1);
  localparam logic [CW-1:0] LD_S2 = CW'(SETTLE_CYC2 - 1);
  localparam logic [CW-1:0] LD_S3 = CW'(SETTLE_CYC3 - 1);

  function automatic logic [CW-1:0] settle_ld(input logic [1:0] sel);
    logic [CW-1:0] v;
    unique case (sel)
      2'h0: v = LD_S0;
      2'h1: v = LD_S1;
      2'h2: v = LD_S2;
      2'h3: v = LD_S3;
    endcase
    return v;
  endfunction

  // Asynchronous pins pass two flip-flops before use.
  logic [1:0] pin_sync_r;
  logic [1:0] poc_sync_r;
  logic [1:0] lvi_sync_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 2'h3;
      poc_sync_r <= 2'h0;
      lvi_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], reset_pin_n};
      poc_sync_r <= {poc_sync_r[0], poc_low};
      lvi_sync_r <= {lvi_sync_r[0], lvi_low};
    end
  end
  wire pin_s = pin_sync_r[1];
  wire poc_s = poc_sync_r[1];
  wire lvi_s = lvi_sync_r[1];

  swrc_pkg::swrc_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic poc_win_r;
  logic [1:0] osc_settle_select_r;
  swrc_pkg::swrc_rsf_t rsf_r, rsf_nxt;
  logic [31:0] prdata_r;
  logic resume_r, vector_r, start_r;
  logic go_int, go_start, ld;
  logic [CW-1:0] ld_val;

  // In port mode the pin only resets inside the window after power-on-clear.
  wire ext_rst = !pin_s && (!reset_pin_is_port || poc_win_r);
  wire rst_any = ext_rst || wdt_overflow || poc_s || lvi_s;
  wire done = (cnt_r == '0);
  wire swrc_pkg::swrc_wake_t unmasked = int_req_flag & ~interrupt_mask_flag;
  wire halt_wake = |unmasked;
  wire ls_run = !(lsosc_stoppable && lsosc_stop_req);
  wire stop_wake = (unmasked.h1 && h1_on_lsosc && ls_run) || unmasked.low_voltage_detector || unmasked.ext;
  wire in_rst_grp = (state_r == swrc_pkg::ST_RESET) || (state_r == swrc_pkg::ST_SETTLE)
                    || (state_r == swrc_pkg::ST_OBREF);

  always_comb begin
    state_nxt = state_r;
    ld = 1'b0;
    ld_val = '0;
    go_int = 1'b0;
    go_start = 1'b0;
    if (rst_any) begin
      state_nxt = swrc_pkg::ST_RESET;
    end else begin
      unique case (state_r)
        swrc_pkg::ST_RESET: begin
          ld = 1'b1;
          if (osc_is_crystal) begin
            state_nxt = swrc_pkg::ST_SETTLE;
            ld_val = settle_ld(ob_settle_sel);
          end else begin
            state_nxt = swrc_pkg::ST_OBREF;
            ld_val = LD_OBREF;
          end
        end
        swrc_pkg::ST_SETTLE: begin
          if (done) begin
            state_nxt = swrc_pkg::ST_OBREF;
            ld = 1'b1;
            ld_val = LD_OBREF;
          end
        end
        swrc_pkg::ST_OBREF: begin
          if (done) begin
            state_nxt = swrc_pkg::ST_RUN;
            go_start = 1'b1;
          end
        end
        swrc_pkg::ST_RUN: begin
          if (stop_exec) begin
            state_nxt = swrc_pkg::ST_STOP;
          end else if (halt_exec) begin
            state_nxt = swrc_pkg::ST_HALT;
          end
        end
        swrc_pkg::ST_HALT: begin
          if (halt_wake) begin
            state_nxt = swrc_pkg::ST_RUN;
            go_int = 1'b1;
          end
        end
        swrc_pkg::ST_STOP: begin
          if (stop_wake) begin
            ld = 1'b1;
            if (osc_is_crystal) begin
              state_nxt = swrc_pkg::ST_WSETTLE;
              ld_val = settle_ld(osc_settle_select_r);
            end else begin
              state_nxt = swrc_pkg::ST_WWAIT;
              ld_val = LD_WAIT;
            end
          end
        end
        swrc_pkg::ST_WSETTLE: begin
          if (done) begin
            state_nxt = swrc_pkg::ST_WWAIT;
            ld = 1'b1;
            ld_val = LD_WAIT;
          end
        end
        swrc_pkg::ST_WWAIT: begin
          if (done) begin
            state_nxt = swrc_pkg::ST_RUN;
            go_int = 1'b1;
          end
        end
      endcase
    end
  end

  assign cnt_nxt = ld ? ld_val : (done ? cnt_r : cnt_r - CW'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= swrc_pkg::ST_RESET;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // The window opens with power-on-clear and closes once the option byte is read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poc_win_r <= 1'b1;
    end else if (poc_s) begin
      poc_win_r <= 1'b1;
    end else if (state_r == swrc_pkg::ST_OBREF && done) begin
      poc_win_r <= 1'b0;
    end
  end

  // Interrupt enable is sampled as execution resumes: at the wake in light sleep, after the wait in deep sleep.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_r <= 1'b0;
      vector_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      resume_r <= go_int && !global_interrupt_enable;
      vector_r <= go_int && global_interrupt_enable;
      start_r <= go_start;
    end
  end

  assign cpu_resume_next = resume_r;
  assign cpu_vector_int = vector_r;
  assign cpu_reset_start = start_r;
  assign reset_vector_addr = swrc_pkg::RESET_VECTOR_ADDR;
  assign reset_pin_input_port = pin_s;
  assign cpu_clk_en = (state_r == swrc_pkg::ST_RUN);
  assign sys_osc_en = (state_r != swrc_pkg::ST_RESET) && (state_r != swrc_pkg::ST_STOP);
  assign lsosc_en = (state_r != swrc_pkg::ST_RESET) && ls_run;
  assign timer16_en = (state_r != swrc_pkg::ST_STOP);
  assign timer8_en = (state_r != swrc_pkg::ST_STOP) || (h1_on_lsosc && lsosc_en);
  assign wdt_en = wdt_on_lsosc ? lsosc_en : cpu_clk_en;
  assign port_latch_hold = (state_r == swrc_pkg::ST_STOP) || (state_r == swrc_pkg::ST_HALT);
  assign detectors_alive = 1'b1;
  assign pins_hiz = in_rst_grp;
  assign reset_indicator_port_output = 1'b0;
  assign reset_indicator_port_output_oe = in_rst_grp;

  // APB slave: one wait-free access phase; read data is captured in the setup cycle.
  wire hit_ctrl = (paddr == swrc_pkg::OFS_CTRL);
  wire hit_stat = (paddr == swrc_pkg::OFS_STATUS);
  wire hit_rsf = (paddr == swrc_pkg::OFS_RSF);
  wire hit = hit_ctrl || hit_stat || hit_rsf;
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr_ctrl = access && pwrite && hit_ctrl;
  wire rd_rsf = access && !pwrite && hit_rsf;
  logic [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? {30'h0, osc_settle_select_r} :
                  hit_stat ? {26'h0, lsosc_en, sys_osc_en, cpu_clk_en, state_r} :
                  hit_rsf ? {30'h0, rsf_r} : 32'h0;
  assign pready = access;
  assign pslverr = access && !hit;
  assign prdata = prdata_r;

  // Only bits that were shown to software are cleared, so a new event is kept.
  wire swrc_pkg::swrc_rsf_t rd_clr = rd_rsf ? swrc_pkg::swrc_rsf_t'(prdata_r[1:0]) : '0;
  wire rsf_wipe = ext_rst || poc_s;
  assign rsf_nxt.wdt = wdt_overflow || (rsf_r.wdt && !rsf_wipe && !rd_clr.wdt);
  assign rsf_nxt.low_voltage_detector = lvi_s || (rsf_r.low_voltage_detector && !rsf_wipe && !rd_clr.low_voltage_detector);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_settle_select_r <= swrc_pkg::OSC_SETTLE_SELECT_RST;
      rsf_r <= '0;
      prdata_r <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        osc_settle_select_r <= pwdata[swrc_pkg::CTRL_OSC_SETTLE_SELECT_LSB +: 2];
      end
      rsf_r <= rsf_nxt;
      if (setup && !pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // Cycles spent in the current state, read only by the checks below.
  logic [CW-1:0] len_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_r <= '0;
    end else begin
      len_r <= (state_nxt != state_r) ? '0 : len_r + CW'(1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RESET_ENTRY: assert property (rst_any |=> state_r == swrc_pkg::ST_RESET)
    else $error("reset did not force the reset state");
  AST_OBREF_LEN: assert property (state_r == swrc_pkg::ST_OBREF
      && state_nxt == swrc_pkg::ST_RUN |-> len_r == CW'(OB_REF_CYC - 1))
    else $error("option byte stop length wrong");
  AST_HALT_WAKE: assert property (state_r == swrc_pkg::ST_HALT && halt_wake && !rst_any
      |=> cpu_clk_en && (cpu_vector_int == $past(global_interrupt_enable))
      && (cpu_resume_next != cpu_vector_int))
    else $error("light sleep wake action wrong");
  AST_HALT_MASKED: assert property (state_r == swrc_pkg::ST_HALT && !halt_wake && !rst_any
      |=> state_r == swrc_pkg::ST_HALT)
    else $error("masked request left light sleep");
  AST_STOP_IMMED: assert property (state_r == swrc_pkg::ST_STOP && stop_wake && !rst_any
      |=> state_r == swrc_pkg::ST_WSETTLE || state_r == swrc_pkg::ST_WWAIT)
    else $error("deep sleep not released");
  AST_WWAIT_LEN: assert property (state_r == swrc_pkg::ST_WWAIT && state_nxt == swrc_pkg::ST_RUN
      |-> len_r >= CW'(swrc_pkg::STOP_WAIT_MIN_CYC - 1)
      && len_r <= CW'(swrc_pkg::STOP_WAIT_MAX_CYC - 1))
    else $error("deep sleep exit wait out of range");
  AST_STOP_GATES: assert property (state_r == swrc_pkg::ST_STOP |-> !sys_osc_en && !cpu_clk_en
      && !timer16_en && port_latch_hold && (timer8_en == (h1_on_lsosc && lsosc_en)))
    else $error("deep sleep gating wrong");
  AST_WDT_LS: assert property (wdt_on_lsosc && !lsosc_stoppable
      && state_r != swrc_pkg::ST_RESET |-> wdt_en)
    else $error("low-speed watchdog stopped");
  AST_RST_OSC: assert property (state_r == swrc_pkg::ST_RESET |-> !sys_osc_en && !lsosc_en
      && pins_hiz && reset_indicator_port_output_oe && !reset_indicator_port_output)
    else $error("reset state outputs wrong");
  AST_CRYSTAL_SEQ: assert property (state_r == swrc_pkg::ST_RESET && !rst_any && osc_is_crystal
      |=> state_r == swrc_pkg::ST_SETTLE ##1 (pins_hiz && !cpu_clk_en))
    else $error("crystal release skipped settle");
  AST_RSF_WIPE: assert property (ext_rst && !wdt_overflow && !lvi_s |=> rsf_r == '0)
    else $error("reset flags not cleared");

  COV_HALT_INT: cover property (state_r == swrc_pkg::ST_HALT ##1 cpu_vector_int);
  COV_STOP_RESUME: cover property (state_r == swrc_pkg::ST_WWAIT ##1 cpu_resume_next);
  COV_STOP_RESET: cover property (state_r == swrc_pkg::ST_STOP ##1 state_r == swrc_pkg::ST_RESET);
  COV_RSF_READ: cover property (rd_rsf && prdata_r[0]);
endmodule

/* inc/swrc_pkg.sv */
package swrc_pkg;
  localparam int CLK_MHZ = 10;
  // Option byte reference stop, typical figure in microseconds.
  localparam int OB_REF_US = 544;
  localparam int OB_REF_MIN_US = 277;
  localparam int OB_REF_MAX_US = 1075;
  // Stop kept after leaving deep sleep, typical, least and longest, microseconds.
  localparam int STOP_WAIT_US = 34;
  localparam int STOP_WAIT_MIN_US = 17;
  localparam int STOP_WAIT_MAX_US = 67;
  localparam int STOP_WAIT_CYC = STOP_WAIT_US * CLK_MHZ;
  localparam int STOP_WAIT_MIN_CYC = STOP_WAIT_MIN_US * CLK_MHZ;
  localparam int STOP_WAIT_MAX_CYC = STOP_WAIT_MAX_US * CLK_MHZ;
  // Oscillator settle choices are powers of two of the system clock period.
  localparam int SETTLE_EXP0 = 10;
  localparam int SETTLE_EXP1 = 12;
  localparam int SETTLE_EXP2 = 15;
  localparam int SETTLE_EXP3 = 17;
  localparam int CNT_W = 18;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RSF = 8'h08;
  localparam int CTRL_OSC_SETTLE_SELECT_LSB = 0;
  localparam logic [1:0] OSC_SETTLE_SELECT_RST = 2'h0;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_SETTLE = 3'h1,
    ST_OBREF = 3'h3,
    ST_RUN = 3'h2,
    ST_STOP = 3'h6,
    ST_WSETTLE = 3'h7,
    ST_WWAIT = 3'h5,
    ST_HALT = 3'h4
  } swrc_state_t;

  typedef struct packed {
    logic h1;
    logic low_voltage_detector;
    logic ext;
    logic other;
  } swrc_wake_t;

  typedef struct packed {
    logic low_voltage_detector;
    logic wdt;
  } swrc_rsf_t;
endpackage

/* sim/swrc_cpu_model.sv */
`timescale 1ns/1ns
// Stand-in for the CPU core and the reset pin driver; the bench calls its tasks.
module swrc_cpu_model (
  input wire logic pclk,
  output logic halt_exec,
  output logic stop_exec,
  output logic reset_pin_n
);
  initial begin
    halt_exec = 1'b0;
    stop_exec = 1'b0;
    reset_pin_n = 1'b1;
  end
  task automatic instr(input logic stop);
    @(posedge pclk);
    halt_exec <= ~stop;
    stop_exec <= stop;
    @(posedge pclk);
    halt_exec <= 1'b0;
    stop_exec <= 1'b0;
  endtask
  // Short requests are stretched, since a brief low on the pin is not a valid reset.
  task automatic pin_reset(input int n);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (n < 20 ? 20 : n) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask
endmodule

/* sim/tb_swrc_top.sv */
`timescale 1ns/1ns
module tb_swrc_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic reset_pin_is_port = 1'b0, poc_low = 1'b0, lvi_low = 1'b0, wdt_overflow = 1'b0;
  logic osc_is_crystal = 1'b0, lsosc_stoppable = 1'b0, lsosc_stop_req = 1'b0;
  logic h1_on_lsosc = 1'b0, wdt_on_lsosc = 1'b0, global_interrupt_enable = 1'b0;
  logic [1:0] ob_settle_sel = 2'h2;
  swrc_pkg::swrc_wake_t int_req_flag = 4'h0, interrupt_mask_flag = 4'hf;
  logic pready, pslverr, reset_pin_n, reset_pin_input_port, halt_exec, stop_exec, e;
  logic cpu_clk_en, cpu_resume_next, cpu_vector_int, cpu_reset_start, sys_osc_en, lsosc_en;
  logic timer16_en, timer8_en, wdt_en, port_latch_hold, detectors_alive, pins_hiz;
  logic reset_indicator_port_output, reset_indicator_port_output_oe;
  logic [15:0] reset_vector_addr;
  int fail_count = 0, checks = 0, n_res = 0, n_vec = 0, n_rst = 0, c, snap, k0;
  int src[4] = '{0, 1, 0, 2};
  logic [31:0] rsf_exp[4] = '{32'h1, 32'h2, 32'h0, 32'h0};

  always #50 pclk = ~pclk;

  swrc_top #(.OB_REF_CYC(20), .SETTLE_CYC2(16), .SETTLE_CYC3(32)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .reset_pin_n, .reset_pin_is_port, .reset_pin_input_port, .poc_low, .lvi_low,
    .wdt_overflow, .osc_is_crystal, .ob_settle_sel, .lsosc_stoppable, .lsosc_stop_req,
    .h1_on_lsosc, .wdt_on_lsosc, .halt_exec, .stop_exec, .int_req_flag,
    .interrupt_mask_flag, .global_interrupt_enable, .cpu_clk_en, .cpu_resume_next,
    .cpu_vector_int, .cpu_reset_start, .reset_vector_addr, .sys_osc_en, .lsosc_en,
    .timer16_en, .timer8_en, .wdt_en, .port_latch_hold, .detectors_alive, .pins_hiz,
    .reset_indicator_port_output, .reset_indicator_port_output_oe);

  swrc_cpu_model cpu (.pclk, .halt_exec, .stop_exec, .reset_pin_n);

  // Pulses last a whole clock, so counting them at the falling edge cannot race the rising one.
  always @(negedge pclk) begin
    n_res += cpu_resume_next;
    n_vec += cpu_vector_int;
    n_rst += cpu_reset_start;
  end

  function automatic int cnt(input int k);
    return k == 0 ? n_res : (k == 1 ? n_vec : n_rst);
  endfunction

  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang(input string m);
    fail_count++;
    $display("wrong value at %0t: %s timed out", $time, m);
    end_sim();
  endtask

  task automatic wait_for(input int k, input int lim);
    snap = cnt(k);
    c = 0;
    while (cnt(k) == snap) begin
      if (c >= lim) hang("event wait");
      @(posedge pclk);
      c++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 16) hang("bus transfer");
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic clear;
    int_req_flag <= 4'h0;
    interrupt_mask_flag <= 4'hf;
  endtask

  task automatic boot(input int lo);
    repeat (4) @(posedge pclk);
    chk(pins_hiz, 1'b1);
    chk(reset_indicator_port_output, 1'b0);
    chk(reset_indicator_port_output_oe, 1'b1);
    wait_for(2, 400);
    chk(c + 4 >= lo, 1'b1);
    chk(reset_vector_addr, 16'h0000);
    @(posedge pclk);
    chk(cpu_clk_en, 1'b1);
  endtask

  task automatic halt_wake(input logic ie, input int k);
    cpu.instr(1'b0);
    @(posedge pclk);
    chk(cpu_clk_en, 1'b0);
    chk(sys_osc_en, 1'b1);
    chk(port_latch_hold, 1'b1);
    global_interrupt_enable <= ie;
    int_req_flag <= 4'h2;
    repeat (4) @(posedge pclk);
    chk(cpu_clk_en, 1'b0);
    interrupt_mask_flag <= 4'hd;
    wait_for(k, 6);
    chk(cpu_clk_en, 1'b1);
    clear;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    chk(sys_osc_en, 1'b0);
    chk(lsosc_en, 1'b0);
    presetn <= 1'b1;
    boot(20);
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h2);
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h3a);
    apb(1'b0, 8'h08, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, 8'h0c, 32'h5);
    chk(e, 1'b1);
    apb(1'b0, 8'h0c, 32'h0);
    chk(r, 32'h0);
    halt_wake(1'b0, 0);
    halt_wake(1'b1, 1);
    cpu.instr(1'b0);
    fork
      cpu.pin_reset(25);
      begin
        repeat (12) @(posedge pclk);
        chk(lsosc_en, 1'b0);
        chk(sys_osc_en, 1'b0);
      end
    join
    boot(20);
    h1_on_lsosc <= 1'b1;
    cpu.instr(1'b1);
    @(posedge pclk);
    chk(sys_osc_en, 1'b0);
    chk(timer16_en, 1'b0);
    chk(timer8_en, 1'b1);
    chk(wdt_en, 1'b0);
    chk(detectors_alive, 1'b1);
    chk(port_latch_hold, 1'b1);
    lsosc_stoppable <= 1'b1;
    lsosc_stop_req <= 1'b1;
    wdt_on_lsosc <= 1'b1;
    @(posedge pclk);
    chk(wdt_en, 1'b0);
    chk(timer8_en, 1'b0);
    lsosc_stop_req <= 1'b0;
    global_interrupt_enable <= 1'b1;
    int_req_flag <= 4'h4;
    interrupt_mask_flag <= 4'hb;
    @(posedge pclk);
    chk(wdt_en, 1'b1);
    wait_for(1, 800);
    chk(c >= 170 && c <= 680, 1'b1);
    clear;
    osc_is_crystal <= 1'b1;
    global_interrupt_enable <= 1'b0;
    int_req_flag <= 4'h2;
    interrupt_mask_flag <= 4'hd;
    cpu.instr(1'b1);
    wait_for(0, 900);
    chk(c >= 186, 1'b1);
    clear;
    cpu.instr(1'b1);
    cpu.pin_reset(20);
    boot(36);
    for (int i = 0; i < 4; i++) begin
      wdt_overflow <= (src[i] == 0);
      lvi_low <= (src[i] == 1);
      poc_low <= (src[i] == 2);
      repeat (3) @(posedge pclk);
      wdt_overflow <= 1'b0;
      lvi_low <= 1'b0;
      poc_low <= 1'b0;
      boot(36);
      if (i != 2) begin
        apb(1'b0, 8'h08, 32'h0);
        chk(r, rsf_exp[i]);
      end
    end
    apb(1'b0, 8'h08, 32'h0);
    chk(r, 32'h0);
    cpu.instr(1'b0);
    k0 = n_res;
    int_req_flag <= 4'h2;
    interrupt_mask_flag <= 4'hd;
    wdt_overflow <= 1'b1;
    @(posedge pclk);
    wdt_overflow <= 1'b0;
    clear;
    boot(36);
    chk(n_res, k0);
    // Port mode outside the power-on-clear window: a low pin must not reset.
    reset_pin_is_port <= 1'b1;
    ob_settle_sel <= 2'h3;
    k0 = n_rst;
    cpu.pin_reset(20);
    chk(reset_pin_input_port, 1'b0);
    repeat (4) @(posedge pclk);
    chk(cpu_clk_en, 1'b1);
    chk(n_rst, k0);
    chk(reset_pin_input_port, 1'b1);
    // Inside the window a low pin holds reset until it goes high again.
    poc_low <= 1'b1;
    repeat (3) @(posedge pclk);
    poc_low <= 1'b0;
    cpu.pin_reset(20);
    boot(52);
    reset_pin_is_port <= 1'b0;
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    hang("whole run");
  end
endmodule
